// [rtl/dcs3_word3.v]
/*
  decodes the third drive control word into setpoint, data set and mode
  selects, and builds the third drive status word from comparisons and the ramp state.
  assumes all inputs synchronous to mclk; the control word is written
  with a one-cycle strobe, telegram type is a level.
*/
`timescale 1ns/1ps
`include "dcs3_consts.vh"
module dcs3_word3 (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire ctrlWrite,
  input wire [`DCS3_WORD_W-1:0] drive_control_word_three,
  input wire [`DCS3_TEL_W-1:0] telegramType,
  input wire [`DCS3_VAL_W-1:0] actualSpeed,
  input wire [`DCS3_VAL_W-1:0] actualCurrent,
  input wire [`DCS3_VAL_W-1:0] dcLinkVoltage,
  input wire [`DCS3_VAL_W-1:0] techCtrlOutput,
  input wire rampActive,
  input wire [`DCS3_VAL_W-1:0] standstill_speed_threshold,
  input wire [`DCS3_VAL_W-1:0] minimum_speed_limit,
  input wire [`DCS3_VAL_W-1:0] current_threshold,
  input wire [`DCS3_VAL_W-1:0] speed_threshold_two,
  input wire [`DCS3_VAL_W-1:0] dc_link_threshold,
  input wire [`DCS3_VAL_W-1:0] tech_ctrl_lower_limit,
  input wire [`DCS3_VAL_W-1:0] tech_ctrl_upper_limit,
  output reg [3:0] fixedSetpointSel_q,
  output reg [1:0] motor_param_set_select_q,
  output reg [1:0] interface_param_set_select_q,
  output reg droopEnable_q,
  output reg torqueControl_q,
  output reg external_fault_source_q,
  output reg externalFault_q,
  output reg [`DCS3_WORD_W-1:0] external_fault_code_q,
  output reg [`DCS3_WORD_W-1:0] drive_status_word_three
);

  // ==========================================================
  // control word capture and decode
  // ==========================================================
  reg [`DCS3_WORD_W-1:0] ctrlWord_q;
  reg tel350_q;
  wire tel350Now;
  wire bound;

  assign tel350Now = (telegramType == `DCS3_TEL_350);
  // bindings hold only while telegram 350 is selected
  assign bound = tel350Now;

  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrlWord_q <= `DCS3_CTRL_RST;
      tel350_q <= 1'b0;
    end else if (ce) begin
      tel350_q <= tel350Now;
      if (tel350_q && !tel350Now) begin
        ctrlWord_q <= `DCS3_CTRL_RST;
      end else if (ctrlWrite && tel350Now) begin
        ctrlWord_q <= drive_control_word_three;
      end
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      fixedSetpointSel_q <= 4'h0;
      motor_param_set_select_q <= 2'h0;
      interface_param_set_select_q <= 2'h0;
      droopEnable_q <= 1'b0;
      torqueControl_q <= 1'b0;
      external_fault_source_q <= 1'b1;
      externalFault_q <= 1'b0;
      external_fault_code_q <= 16'h0000;
    end else if (ce) begin
      if (!bound) begin
        // unbound: all zero, fault source held at constant one
        fixedSetpointSel_q <= 4'h0;
        motor_param_set_select_q <= 2'h0;
        interface_param_set_select_q <= 2'h0;
        droopEnable_q <= 1'b0;
        torqueControl_q <= 1'b0;
        external_fault_source_q <= 1'b1;
      end else begin
        fixedSetpointSel_q <=
          ctrlWord_q[`DCS3_CW_FIX_HI:`DCS3_CW_FIX_LO];
        motor_param_set_select_q <=
          ctrlWord_q[`DCS3_CW_MDS_HI:`DCS3_CW_MDS_LO];
        // bit 0 of this select is tied to zero
        interface_param_set_select_q <=
          {ctrlWord_q[`DCS3_CW_IDS1], 1'b0};
        droopEnable_q <= ctrlWord_q[`DCS3_CW_DROOP];
        torqueControl_q <= ctrlWord_q[`DCS3_CW_TORQUE];
        external_fault_source_q <= ctrlWord_q[`DCS3_CW_EXTFLT_N];
      end
      // bits 6 to 10 and 14 never read
      externalFault_q <= bound ? !ctrlWord_q[`DCS3_CW_EXTFLT_N] : 1'b0;
      external_fault_code_q <= (bound && !ctrlWord_q[`DCS3_CW_EXTFLT_N]) ?
        `DCS3_EXT_FAULT_CODE : 16'h0000;
    end
  end

  // ==========================================================
  // status comparisons and ramp done flag
  // ==========================================================
  wire [`DCS3_VAL_W-1:0] speedMag;
  wire standstillFlag;
  wire minSpeedFlag;
  wire currentFlag;
  wire speedTwoFlag;
  wire dcLinkFlag;
  wire techUpperFlag;
  wire techLowerFlag;
  reg rampDone_q;

  dcs3_abs #(.W(`DCS3_VAL_W)) uAbs (
    .val(actualSpeed),
    .mag(speedMag)
  );

  dcs3_cmp_gt #(.W(`DCS3_VAL_W), .OR_EQUAL(0)) uStand (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .a(speedMag), .b(standstill_speed_threshold), .flag(standstillFlag)
  );
  dcs3_cmp_gt #(.W(`DCS3_VAL_W), .OR_EQUAL(0)) uMin (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .a(speedMag), .b(minimum_speed_limit), .flag(minSpeedFlag)
  );
  dcs3_cmp_gt #(.W(`DCS3_VAL_W), .OR_EQUAL(1)) uCurr (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .a(actualCurrent), .b(current_threshold), .flag(currentFlag)
  );
  dcs3_cmp_gt #(.W(`DCS3_VAL_W), .OR_EQUAL(0)) uSpd2 (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .a(speedMag), .b(speed_threshold_two), .flag(speedTwoFlag)
  );
  dcs3_cmp_gt #(.W(`DCS3_VAL_W), .OR_EQUAL(0)) uDc (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .a(dcLinkVoltage), .b(dc_link_threshold), .flag(dcLinkFlag)
  );
  dcs3_cmp_gt #(.W(`DCS3_VAL_W), .OR_EQUAL(0)) uTechHi (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .a(techCtrlOutput), .b(tech_ctrl_upper_limit), .flag(techUpperFlag)
  );
  // lower limit: output <= limit, i.e. limit >= output
  dcs3_cmp_gt #(.W(`DCS3_VAL_W), .OR_EQUAL(1)) uTechLo (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .a(tech_ctrl_lower_limit), .b(techCtrlOutput), .flag(techLowerFlag)
  );

  always @(posedge mclk) begin
    if (!rst_n) begin
      rampDone_q <= 1'b0;
    end else if (ce) begin
      rampDone_q <= !rampActive;
    end
  end

  // ==========================================================
  // status word assembly
  // ==========================================================
  reg [`DCS3_WORD_W-1:0] statusWord_d;

  always @* begin
    statusWord_d = 16'h0000;
    statusWord_d[`DCS3_SW_STANDSTILL] = standstillFlag;
    statusWord_d[`DCS3_SW_MINSPD] = minSpeedFlag;
    statusWord_d[`DCS3_SW_CURR] = currentFlag;
    statusWord_d[`DCS3_SW_SPD2_HI] = speedTwoFlag;
    statusWord_d[`DCS3_SW_SPD2_LO] = !speedTwoFlag;
    statusWord_d[`DCS3_SW_DC_LO] = !dcLinkFlag;
    statusWord_d[`DCS3_SW_DC_HI] = dcLinkFlag;
    statusWord_d[`DCS3_SW_RAMP_DONE] = rampDone_q;
    statusWord_d[`DCS3_SW_TECH_LO] = techLowerFlag;
    statusWord_d[`DCS3_SW_TECH_HI] = techUpperFlag;
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      drive_status_word_three <= 16'h0000;
    end else if (ce) begin
      drive_status_word_three <= statusWord_d;
    end
  end

endmodule // dcs3_word3

// [pkg/dcs3_consts.vh]
/*
  constants for the third control and status word block: bit positions,
  telegram code and reset values.
  assumes inclusion by bare name from the rtl files.
*/
`ifndef DCS3_CONSTS_VH
`define DCS3_CONSTS_VH

`define DCS3_WORD_W 16
`define DCS3_VAL_W 16
`define DCS3_TEL_W 10
`define DCS3_TEL_350 10'h15e

// control word bit positions
`define DCS3_CW_FIX_LO 0
`define DCS3_CW_FIX_HI 3
`define DCS3_CW_MDS_LO 4
`define DCS3_CW_MDS_HI 5
`define DCS3_CW_DROOP 11
`define DCS3_CW_TORQUE 12
`define DCS3_CW_EXTFLT_N 13
`define DCS3_CW_IDS1 15

// status word bit positions
`define DCS3_SW_STANDSTILL 1
`define DCS3_SW_MINSPD 2
`define DCS3_SW_CURR 3
`define DCS3_SW_SPD2_HI 4
`define DCS3_SW_SPD2_LO 5
`define DCS3_SW_DC_LO 7
`define DCS3_SW_DC_HI 8
`define DCS3_SW_RAMP_DONE 9
`define DCS3_SW_TECH_LO 10
`define DCS3_SW_TECH_HI 11

// fault code raised by the external fault input, value arbitrary
`define DCS3_EXT_FAULT_CODE 16'h0001
`define DCS3_CTRL_RST 16'h2000

`endif

// [rtl/dcs3_cmp_gt.v]
/*
  registered comparator: flags a > b, or a >= b when orEqual is set.
  assumes operands synchronous to mclk.
*/
`timescale 1ns/1ps
module dcs3_cmp_gt #(
  parameter W = 16,
  parameter OR_EQUAL = 0
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  output reg flag
);
  always @(posedge mclk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (ce) begin
      flag <= (OR_EQUAL != 0) ? (a >= b) : (a > b);
    end
  end
endmodule // dcs3_cmp_gt

// [rtl/dcs3_abs.v]
/*
  absolute value of a signed two's complement word.
  assumes a combinational use by the caller.
*/
`timescale 1ns/1ps
module dcs3_abs #(
  parameter W = 16
) (
  input wire [W-1:0] val,
  output wire [W-1:0] mag
);
  assign mag = val[W-1] ? (~val + {{(W-1){1'b0}}, 1'b1}) : val;
endmodule // dcs3_abs

// [verif/dcs3_word3_assertions.sv]
/* checker for the third word block ports.
   assumes ce held high and a bind onto dcs3_word3. */
`timescale 1ns/1ps
module dcs3_word3_chk (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire ctrlWrite,
  input wire [15:0] drive_control_word_three,
  input wire [9:0] telegramType,
  input wire [3:0] fixedSetpointSel_q,
  input wire droopEnable_q,
  input wire torqueControl_q,
  input wire external_fault_source_q,
  input wire externalFault_q,
  input wire [15:0] drive_status_word_three
);
  // ==========================================
  // sequences
  wire [15:0] cw = drive_control_word_three;
  wire [15:0] sw = drive_status_word_three;
  wire tel350 = telegramType == 10'h15e;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence sWrite;
    ce && ctrlWrite && tel350 ##1 (ce && tel350)[*2];
  endsequence
  sequence sRun;
    rst_n[*3];
  endsequence
  // ==========================================
  // properties
  AST_FIX: assert property (sWrite |->
    fixedSetpointSel_q == $past(cw[3:0], 2)) else $error("fixed sel");
  AST_DROOP: assert property (sWrite |->
    droopEnable_q == $past(cw[11], 2)) else $error("droop");
  AST_TORQ: assert property (sWrite |->
    torqueControl_q == $past(cw[12], 2)) else $error("torque");
  AST_EXTFLT: assert property (sWrite |->
    externalFault_q != $past(cw[13], 2) &&
    external_fault_source_q == $past(cw[13], 2)) else $error("ext fault");
  AST_TELOFF: assert property ($past(tel350) && !tel350 |=>
    !droopEnable_q && !torqueControl_q && !externalFault_q &&
    external_fault_source_q) else $error("telegram leave");
  AST_SPD2: assert property (sRun |-> sw[4] != sw[5])
    else $error("speed two pair");
  AST_DCLINK: assert property (sRun |-> sw[7] != sw[8])
    else $error("dc link pair");
  AST_SPARE: assert property (sw[15:12] == 4'h0)
    else $error("spare bits");
endmodule // dcs3_word3_chk

bind dcs3_word3 dcs3_word3_chk u_dcs3_word3_chk (.mclk, .rst_n, .ce,
  .ctrlWrite, .drive_control_word_three, .telegramType,
  .fixedSetpointSel_q, .droopEnable_q, .torqueControl_q,
  .external_fault_source_q, .externalFault_q, .drive_status_word_three);

// [verif/dcs3_fbus_ctrl.sv]
/* fieldbus controller model: sends third control words.
   assumes the device samples on the rising edge of mclk. */
`timescale 1ns/1ps
module dcs3_fbus_ctrl (
  input wire mclk,
  output reg ctrlWrite,
  output reg [15:0] cw
);
  initial begin
    ctrlWrite = 1'b0;
    cw = 16'h2000;
  end
  // whole 16-bit word per write, maker specific
  task send(input logic [15:0] w);
    @(negedge mclk);
    ctrlWrite = 1'b1;
    cw = w;
    @(negedge mclk);
    ctrlWrite = 1'b0;
    cw = ~w;
  endtask
endmodule // dcs3_fbus_ctrl

// [verif/tb_dcs3_word3.sv]
/* testbench for the third word block.
   assumes the fieldbus model and the bound checker. */
`timescale 1ns/1ps
module tb_dcs3_word3;
  logic mclk = 0;
  logic rst_n = 0;
  logic [9:0] tel = 10'h15e;
  logic [15:0] spd = 0, cur = 0, dc = 0, tech = 0;
  logic ramp = 0;
  logic ce = 1;
  logic [15:0] thr [0:6];
  wire ctrlWrite, droop, torq, src, flt;
  wire [15:0] cw, sw, code;
  wire [3:0] fix;
  wire [1:0] mSel, iSel;
  wire [15:0] dec = {4'h0, fix, mSel, iSel, droop, torq, src, flt};
  int n_errors = 0;
  int compares = 0;
  dcs3_fbus_ctrl u_dcs3_fbus_ctrl (.mclk(mclk), .ctrlWrite(ctrlWrite),
    .cw(cw));
  dcs3_word3 u_dcs3_word3 (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .ctrlWrite(ctrlWrite), .drive_control_word_three(cw),
    .telegramType(tel), .actualSpeed(spd), .actualCurrent(cur),
    .dcLinkVoltage(dc), .techCtrlOutput(tech), .rampActive(ramp),
    .standstill_speed_threshold(thr[0]), .minimum_speed_limit(thr[1]),
    .current_threshold(thr[2]), .speed_threshold_two(thr[3]),
    .dc_link_threshold(thr[4]), .tech_ctrl_lower_limit(thr[5]),
    .tech_ctrl_upper_limit(thr[6]), .fixedSetpointSel_q(fix),
    .motor_param_set_select_q(mSel), .interface_param_set_select_q(iSel),
    .droopEnable_q(droop), .torqueControl_q(torq),
    .external_fault_source_q(src), .externalFault_q(flt),
    .external_fault_code_q(code), .drive_status_word_three(sw));
  initial forever #10 mclk = ~mclk;
  // ==========================================
  // helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task settle;
    repeat (3) @(negedge mclk);
  endtask
  task give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task t_decode;
    logic [3:0] i;
    for (int k = 0; k < 16; k++) begin
      i = k[3:0];
      u_dcs3_fbus_ctrl.send({i[3], 1'b1, i[2:0], 3'h4, 2'h3, i[3:2], i});
      settle;
      chk(dec, {4'h0, i, i[3:2], i[3], 1'b0, i[0], i[1], i[2], ~i[2]});
      chk(code, {15'h0, ~i[2]});
    end
  endtask
  task t_tel;
    u_dcs3_fbus_ctrl.send(16'h1805);
    tel = 10'h15f;
    settle;
    chk(dec, 16'h0002);
    chk(code, 16'h0000);
    u_dcs3_fbus_ctrl.send(16'h1805);
    tel = 10'h15e;
    settle;
    chk(dec, 16'h0002);
  endtask
  task t_ce;
    ce = 1'b0;
    u_dcs3_fbus_ctrl.send(16'h0000);
    spd = 16'h0201;
    settle;
    chk(dec, 16'h0002);
    chk(sw, 16'h06a0);
    spd = 16'h0000;
    ce = 1'b1;
    settle;
    chk(dec, 16'h0002);
    chk(sw, 16'h06a0);
  endtask
  task t_stat(input logic [15:0] s, c, d, t, input logic r,
              input logic [15:0] exp);
    spd = s;
    cur = c;
    dc = d;
    tech = t;
    ramp = r;
    settle;
    chk(sw, exp);
  endtask
  initial begin
    thr = '{16'h0080, 16'h0100, 16'h0200, 16'h0200, 16'h0300, 16'h0050,
      16'h0060};
    repeat (10) @(negedge mclk);
    rst_n = 1;
    t_decode;
    t_tel;
    t_ce;
    t_stat(16'hff00, 16'h0200, 16'h0300, 16'h0050, 1'b0, 16'h06aa);
    t_stat(16'h0201, 16'h01ff, 16'h0301, 16'h0061, 1'b1, 16'h0916);
    t_stat(16'h0080, 16'hffff, 16'h0000, 16'h0060, 1'b0, 16'h02a8);
    give_verdict;
  end
  initial begin
    #100000;
    n_errors++;
    give_verdict;
  end
endmodule // tb_dcs3_word3
